//--- logic/ata_cmd_core.sv
// Task-file command engine for block-count setup, diagnostic and track format.
`timescale 1ns/1ps
`default_nettype none
`include "ata_cmd_consts.svh"
module ata_cmd_core
    import ata_cmd_pkg::*;
#(
    parameter int unsigned PDIAG_WAIT_CYC = `PDIAG_WAIT_S * `CLK_HZ
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [11:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output var  logic [31:0] dat_o,
    output var  logic        ack_o,
    output var  logic        intrq_o,
    output var  logic        selftest_start_o,
    input  wire logic        selftest_done_i,
    input  wire logic [7:0]  selftest_code_i,
    input  wire logic        dev1_present_i,
    input  wire logic        pdiag_n_i
);

    core_s       s_ff;
    core_s       nxt_s;
    logic [15:0] buf_rdata;
    logic        buf_we;
    logic [9:0]  idx;
    logic        req;
    logic        wr;
    logic        rd;
    logic        idle;
    logic        srst_rise;
    logic [7:0]  status;
    logic [15:0] id59;

    // Besides zero, only these four block counts are accepted by the setup command.
    function automatic logic count_ok(input logic [7:0] cnt);
        count_ok = (cnt == 8'h02) || (cnt == 8'h04) ||
                   (cnt == 8'h08) || (cnt == 8'h10);
    endfunction

    // Bus decode; a request is taken once and answered in the next cycle.
    assign idx  = adr_i[11:2];
    assign req  = cyc_i && stb_i && !s_ff.ack;
    assign wr   = req && we_i;
    assign rd   = req && !we_i;
    assign idle = (s_ff.state == ST_IDLE) && !s_ff.bsy && !s_ff.drq;

    // Status byte and the live identify word.
    assign status = {s_ff.bsy, !s_ff.bsy, 1'b0, 1'b1, s_ff.drq, 2'b00, s_ff.err};
    assign id59   = s_ff.mult_en ? {`ID59_ENABLED, s_ff.mult_cnt} : 16'h0000;

    // Each finished parameter word goes straight into the buffer.
    assign buf_we = wr && sel_i[0] && sel_i[1] && (idx == `IDX_DATA) &&
                    (s_ff.state == ST_FMT_XFER) && s_ff.drq;

    param_buffer u_param_buffer (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .we_i    (buf_we),
        .waddr_i (s_ff.wptr),
        .wdata_i (dat_i[15:0]),
        .raddr_i (s_ff.wptr),
        .rdata_o (buf_rdata)
    );

    // Next-state logic: bus side first, then the sequencer, then soft reset.
    always_comb begin
        nxt_s          = s_ff;
        nxt_s.ack      = 1'b0;
        nxt_s.st_start = 1'b0;
        srst_rise      = 1'b0;

        if (req) begin
            nxt_s.ack = 1'b1;
            unique case (idx)
                `IDX_DATA:    nxt_s.rdat = {16'h0000, buf_rdata};
                `IDX_ERROR:   nxt_s.rdat = {24'h000000, s_ff.error};
                `IDX_SECCNT:  nxt_s.rdat = {24'h000000, s_ff.sc};
                `IDX_SECNUM:  nxt_s.rdat = {24'h000000, s_ff.sn};
                `IDX_CYLLO:   nxt_s.rdat = {24'h000000, s_ff.cl};
                `IDX_CYLHI:   nxt_s.rdat = {24'h000000, s_ff.ch};
                `IDX_DRVHEAD: nxt_s.rdat = {24'h000000, s_ff.dh};
                `IDX_CMDSTAT: nxt_s.rdat = {24'h000000, status};
                `IDX_ID47:    nxt_s.rdat = {16'h0000, `ID47_VALUE};
                `IDX_ID59:    nxt_s.rdat = {16'h0000, id59};
                `IDX_DEVCTL:  nxt_s.rdat = {29'h0000000, s_ff.srst, 2'b00};
                default:      nxt_s.rdat = 32'h00000000;
            endcase
        end

        // Reading status acknowledges the interrupt; a later set still wins.
        if (rd && (idx == `IDX_CMDSTAT)) begin
            nxt_s.intrq = 1'b0;
        end

        // Task-file writes are ignored while a command owns the registers.
        if (wr && sel_i[0] && idle) begin
            unique case (idx)
                `IDX_ERROR:   nxt_s.feat = dat_i[7:0];
                `IDX_SECCNT:  nxt_s.sc   = dat_i[7:0];
                `IDX_SECNUM:  nxt_s.sn   = dat_i[7:0];
                `IDX_CYLLO:   nxt_s.cl   = dat_i[7:0];
                `IDX_CYLHI:   nxt_s.ch   = dat_i[7:0];
                `IDX_DRVHEAD: nxt_s.dh   = dat_i[7:0];
                default: ;
            endcase
        end

        // The device-control register stays writable so a hung command can be reset.
        if (wr && sel_i[0] && (idx == `IDX_DEVCTL)) begin
            nxt_s.srst = dat_i[`DEVCTL_SRST];
        end

        // Command dispatch; the device-select bit is not looked at.
        if (wr && sel_i[0] && idle && (idx == `IDX_CMDSTAT)) begin
            nxt_s.err = 1'b0;
            unique case (dat_i[7:0])
                `CMD_SET_MULT: begin
                    nxt_s.state = ST_SET_MULT;
                    nxt_s.bsy   = 1'b1;
                end
                `CMD_DIAG: begin
                    nxt_s.state    = ST_DIAG_RUN;
                    nxt_s.bsy      = 1'b1;
                    nxt_s.st_start = 1'b1;
                end
                `CMD_FMT_TRACK: begin
                    nxt_s.state = ST_FMT_XFER;
                    nxt_s.drq   = 1'b1;
                    nxt_s.wptr  = 8'h00;
                end
                default: begin
                    nxt_s.err   = 1'b1;
                    nxt_s.error = `ERR_ABORT;
                    nxt_s.intrq = 1'b1;
                end
            endcase
        end

        // Sequencer.
        unique case (s_ff.state)
            ST_IDLE: ;
            ST_SET_MULT: begin
                if (count_ok(s_ff.sc)) begin
                    nxt_s.mult_en  = 1'b1;
                    nxt_s.mult_cnt = s_ff.sc;
                end else if (s_ff.sc == 8'h00) begin
                    nxt_s.mult_en = 1'b0;
                end else begin
                    nxt_s.mult_en = 1'b0;
                    nxt_s.err     = 1'b1;
                    nxt_s.error   = `ERR_ABORT;
                end
                nxt_s.bsy   = 1'b0;
                nxt_s.intrq = 1'b1;
                nxt_s.state = ST_IDLE;
            end
            ST_DIAG_RUN: begin
                if (selftest_done_i) begin
                    nxt_s.self_code = selftest_code_i;
                    nxt_s.wait_cnt  = 32'h00000000;
                    if (dev1_present_i) begin
                        nxt_s.state = ST_DIAG_WT;
                    end else begin
                        nxt_s.error = selftest_code_i;
                        nxt_s.state = ST_IDLE;
                    end
                end
            end
            ST_DIAG_WT: begin
                // A pass signal from the second device ends the wait early.
                if (!pdiag_n_i) begin
                    nxt_s.error = s_ff.self_code;
                    nxt_s.state = ST_IDLE;
                end else if (s_ff.wait_cnt == PDIAG_WAIT_CYC - 1) begin
                    nxt_s.error = s_ff.self_code | `DIAG_DEV1_FAIL;
                    nxt_s.state = ST_IDLE;
                end else begin
                    nxt_s.wait_cnt = s_ff.wait_cnt + 32'h00000001;
                end
            end
            ST_FMT_XFER: begin
                if (buf_we) begin
                    nxt_s.wptr = s_ff.wptr + 8'h01;
                    if (s_ff.wptr == `PARAM_LAST) begin
                        nxt_s.drq   = 1'b0;
                        nxt_s.bsy   = 1'b1;
                        nxt_s.state = ST_FMT_DONE;
                    end
                end
            end
            ST_FMT_DONE: begin
                nxt_s.bsy   = 1'b0;
                nxt_s.intrq = 1'b1;
                nxt_s.state = ST_IDLE;
            end
            default: nxt_s.state = ST_IDLE;
        endcase

        // Common diagnostic ending: fixed task-file image, busy off, interrupt.
        if ((s_ff.state inside {ST_DIAG_RUN, ST_DIAG_WT}) && (nxt_s.state == ST_IDLE)) begin
            nxt_s.bsy   = 1'b0;
            nxt_s.intrq = 1'b1;
            nxt_s.err   = 1'b0;
            nxt_s.dh    = 8'h00;
            nxt_s.ch    = 8'h00;
            nxt_s.cl    = 8'h00;
            nxt_s.sn    = 8'h01;
            nxt_s.sc    = 8'h01;
        end

        // Soft reset aborts work but deliberately leaves multiple mode alone.
        if (nxt_s.srst && !s_ff.srst) begin
            srst_rise   = 1'b1;
            nxt_s.state = ST_IDLE;
            nxt_s.bsy   = 1'b0;
            nxt_s.drq   = 1'b0;
            nxt_s.err   = 1'b0;
            nxt_s.intrq = 1'b0;
            nxt_s.error = `DIAG_OK;
        end
    end

    // State register; clock enable low freezes everything except reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_ff       <= '0;
            s_ff.error <= `DIAG_OK;
        end else if (ce_i) begin
            s_ff <= nxt_s;
        end
    end

    assign dat_o            = s_ff.rdat;
    assign ack_o            = s_ff.ack;
    assign intrq_o          = s_ff.intrq;
    assign selftest_start_o = s_ff.st_start;

    // Sequencing checks; a soft reset in the same cycle overrides them on purpose.
    a_busy_drq_excl: assert property (@(posedge clk_i) disable iff (rst_i)
        !(s_ff.bsy && s_ff.drq))
        else $error("busy and drq set together");

    a_setmul_store: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_ff.state == ST_SET_MULT && ce_i && count_ok(s_ff.sc) && !srst_rise)
        |=> (s_ff.mult_en && s_ff.mult_cnt == $past(s_ff.sc) && !s_ff.err))
        else $error("good block count not stored");

    a_setmul_abort: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_ff.state == ST_SET_MULT && ce_i && !count_ok(s_ff.sc) && s_ff.sc != 8'h00
         && !srst_rise)
        |=> (!s_ff.mult_en && s_ff.err && s_ff.error == `ERR_ABORT))
        else $error("bad block count not aborted");

    a_setmul_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_ff.state == ST_SET_MULT && ce_i && s_ff.sc == 8'h00 && !srst_rise)
        |=> (!s_ff.mult_en && !s_ff.err))
        else $error("zero count did not disable");

    a_setmul_done: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_ff.state == ST_SET_MULT && ce_i && !srst_rise)
        |=> (!s_ff.bsy && s_ff.intrq && s_ff.state == ST_IDLE))
        else $error("setup did not complete");

    a_srst_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
        (srst_rise && ce_i)
        |=> (s_ff.mult_en == $past(s_ff.mult_en) && s_ff.mult_cnt == $past(s_ff.mult_cnt)))
        else $error("soft reset changed multiple mode");

    a_pdiag_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_ff.state == ST_DIAG_WT && ce_i && pdiag_n_i && !srst_rise &&
         s_ff.wait_cnt == PDIAG_WAIT_CYC - 1)
        |=> (s_ff.error == ($past(s_ff.self_code) | `DIAG_DEV1_FAIL) && s_ff.intrq
             && !s_ff.bsy))
        else $error("second device timeout not reported");

    a_id59_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd && ce_i && idx == `IDX_ID59 && s_ff.mult_en)
        |=> (ack_o && dat_o == {16'h0000, `ID59_ENABLED, $past(s_ff.mult_cnt)}))
        else $error("identify word 59 wrong");

    a_fmt_last: assert property (@(posedge clk_i) disable iff (rst_i)
        (buf_we && ce_i && s_ff.wptr == `PARAM_LAST && !srst_rise)
        |=> (s_ff.bsy && !s_ff.drq) ##1 (!ce_i || (!s_ff.bsy && s_ff.intrq)))
        else $error("format block end sequence wrong");

    a_diag_alone: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_ff.state == ST_DIAG_RUN && ce_i && selftest_done_i && !dev1_present_i
         && !srst_rise)
        |=> (s_ff.error == $past(selftest_code_i) && s_ff.intrq && !s_ff.bsy))
        else $error("own diagnostic result not reported");

    a_diag_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_ff.state == ST_DIAG_WT && ce_i && !pdiag_n_i && !srst_rise)
        |=> (s_ff.error == $past(s_ff.self_code) && s_ff.intrq && !s_ff.bsy))
        else $error("second device pass not honoured");

    a_fmt_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && ce_i && sel_i[0] && idle && idx == `IDX_CMDSTAT &&
         dat_i[7:0] == `CMD_FMT_TRACK && !srst_rise)
        |=> (s_ff.drq && !s_ff.bsy && s_ff.wptr == 8'h00))
        else $error("format did not raise drq");

endmodule
`default_nettype wire

//--- logic/ata_cmd_consts.svh
// Offsets, field positions, codes and timing counts of the ATA command block.
`ifndef ATA_CMD_CONSTS_SVH
`define ATA_CMD_CONSTS_SVH

// Register indexes; the byte address on the bus is four times the index.
`define IDX_DATA       10'h1F0
`define IDX_ERROR      10'h1F1
`define IDX_SECCNT     10'h1F2
`define IDX_SECNUM     10'h1F3
`define IDX_CYLLO      10'h1F4
`define IDX_CYLHI      10'h1F5
`define IDX_DRVHEAD    10'h1F6
`define IDX_CMDSTAT    10'h1F7
`define IDX_ID47       10'h1E0
`define IDX_ID59       10'h1E1
`define IDX_DEVCTL     10'h3F6

// Command codes.
`define CMD_SET_MULT   8'hC6
`define CMD_DIAG       8'h90
`define CMD_FMT_TRACK  8'h50

// Status and device-control bit positions.
`define ST_BSY         7
`define ST_DRDY        6
`define ST_DSC         4
`define ST_DRQ         3
`define ST_ERR         0
`define DEVCTL_SRST    2

// Error and diagnostic codes.
`define ERR_ABORT      8'h04
`define DIAG_OK        8'h01
`define DIAG_BUF_ERR   8'h03
`define DIAG_ROM_ERR   8'h05
`define DIAG_DEV1_FAIL 8'h80

// Identify words.
`define ID47_VALUE     16'h8010
`define ID59_ENABLED   8'h01

// Parameter block of 512 bytes moved as 16-bit words.
`define PARAM_WORDS    256
`define PARAM_LAST     8'hFF

// Timing.
`define CLK_HZ         25000000
`define PDIAG_WAIT_S   5

`endif

//--- logic/ata_cmd_pkg.sv
// Types of the ATA command block: sequencer states and the state record.
package ata_cmd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_SET_MULT = 3'b001,
        ST_DIAG_RUN = 3'b011,
        ST_DIAG_WT  = 3'b010,
        ST_FMT_XFER = 3'b110,
        ST_FMT_DONE = 3'b111
    } state_e;

    typedef struct packed {
        state_e      state;
        logic        bsy;
        logic        drq;
        logic        err;
        logic        intrq;
        logic        mult_en;
        logic [7:0]  mult_cnt;
        logic [7:0]  error;
        logic [7:0]  feat;
        logic [7:0]  sc;
        logic [7:0]  sn;
        logic [7:0]  cl;
        logic [7:0]  ch;
        logic [7:0]  dh;
        logic        srst;
        logic [7:0]  self_code;
        logic [31:0] wait_cnt;
        logic [7:0]  wptr;
        logic        ack;
        logic [31:0] rdat;
        logic        st_start;
    } core_s;

endpackage

//--- logic/param_buffer.sv
// Word buffer that receives the track-format parameter block.
`timescale 1ns/1ps
`default_nettype none
module param_buffer (
    input  wire logic        clk_i,
    input  wire logic        ce_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  waddr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [7:0]  raddr_i,
    output var  logic [15:0] rdata_o
);

    logic [15:0] mem_ff [0:255];

    // Read data leave through a register so the caller sees a flop output.
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem_ff[waddr_i] <= wdata_i;
            end
            rdata_o <= mem_ff[raddr_i];
        end
    end

endmodule
`default_nettype wire

//--- sim/diag_partner.sv
// Behavioural self-test engine and second device that face the command engine.
`timescale 1ns/1ps
`default_nettype none
module diag_partner (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic       present_i,
    input  wire logic       dev1_ok_i,
    input  wire logic [7:0] code_i,
    output var  logic       done_o,
    output var  logic [7:0] code_o,
    output var  logic       pdiag_n_o
);
    logic [3:0] cnt_ff;

    // Both devices start on the same pulse; the count parks at eight until the next start.
    always_ff @(posedge clk_i) begin
        if (rst_i || start_i) begin
            cnt_ff <= {3'h0, start_i && !rst_i};
        end else if (cnt_ff != 4'h0 && cnt_ff != 4'h8) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // The code is valid only with done; its inverse elsewhere keeps a stale value from matching.
    assign done_o = (cnt_ff == 4'h4);
    assign code_o = done_o ? code_i : ~code_i;

    // A passing second device pulls the line low well inside the wait; else the pull-up wins.
    assign pdiag_n_o = !(present_i && dev1_ok_i && cnt_ff == 4'h8);
endmodule
`default_nettype wire

//--- sim/ata_multiple_diag_format_cmds_bench.sv
// Self-checking bench for the task-file command engine over the register bus.
`timescale 1ns/1ps
`default_nettype none
`include "ata_cmd_consts.svh"
module ata_multiple_diag_format_cmds_bench;
    localparam int WAIT_CYC = 50;
    logic        clk, rst, ce, cyc, stb, we, ack, intrq;
    logic        st_start, st_done, present, dev1_ok, pdiag_n;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  st_code, own_code;
    int          n_fail = 0;
    int          checks_done = 0;

    // The diagnostic wait is shortened so the timeout path stays cheap to run.
    ata_cmd_core #(.PDIAG_WAIT_CYC(WAIT_CYC)) dut (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .intrq_o(intrq), .selftest_start_o(st_start), .selftest_done_i(st_done),
        .selftest_code_i(st_code), .dev1_present_i(present), .pdiag_n_i(pdiag_n));

    diag_partner partner (
        .clk_i(clk), .rst_i(rst), .start_i(st_start), .present_i(present),
        .dev1_ok_i(dev1_ok), .code_i(own_code), .done_o(st_done), .code_o(st_code),
        .pdiag_n_o(pdiag_n));

    // Free-running 25 MHz clock.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request is held until ack is sampled high at an edge.
    task automatic bus(input logic w, input logic [9:0] idx, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= (idx == `IDX_DATA) ? 4'h3 : 4'h1;
        wdat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        if (ack !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: bus cycle never acknowledged", $time);
            end_of_test();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, idx, 32'h0, q);
        check(q, exp);
    endtask

    // Bounded wait for the interrupt; running out ends the run as a failure.
    task automatic wait_irq(input int lim);
        int n;
        n = 0;
        while (intrq !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (intrq !== 1'b1) begin
            n_fail++;
            $display("Error at %0t: interrupt never came", $time);
            end_of_test();
        end
    endtask

    // Issues a command, waits for completion and reads status, which clears the interrupt.
    task automatic run_cmd(input logic [7:0] code, input logic [7:0] st);
        wr(`IDX_CMDSTAT, {24'h0, code});
        wait_irq(300);
        rd_chk(`IDX_CMDSTAT, {24'h0, st});
        check({31'h0, intrq}, 32'h0);
    endtask

    task automatic t_reset();
        rd_chk(`IDX_CMDSTAT, 32'h50);
        rd_chk(`IDX_ERROR, 32'h01);
        rd_chk(`IDX_ID47, {16'h0, `ID47_VALUE});
        rd_chk(`IDX_ID59, 32'h0);
        rd_chk(10'h100, 32'h0);
        run_cmd(8'h00, 8'h51);
        rd_chk(`IDX_ERROR, {24'h0, `ERR_ABORT});
    endtask

    // Clock enable low freezes the engine, so a held request is answered only once it rises.
    task automatic t_ce();
        int n;
        n = 0;
        ce <= 1'b0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= 1'b0;
        adr <= {`IDX_ID47, 2'b00};
        sel <= 4'h1;
        repeat (3) @(posedge clk);
        check({31'h0, ack}, 32'h0);
        ce <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        check({31'h0, ack}, 32'h1);
        if (ack !== 1'b1) begin
            end_of_test();
        end
        check(rdat, {16'h0, `ID47_VALUE});
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    // Good counts, then a bad one after a good one, then zero after a good one.
    task automatic t_set_mult();
        logic [7:0] cnts [7] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h03, 8'h08, 8'h00};
        logic ok;
        foreach (cnts[i]) begin
            ok = cnts[i] inside {8'h02, 8'h04, 8'h08, 8'h10};
            wr(`IDX_SECCNT, {24'h0, cnts[i]});
            run_cmd(`CMD_SET_MULT, (ok || cnts[i] == 8'h0) ? 8'h50 : 8'h51);
            if (!ok && cnts[i] != 8'h0) rd_chk(`IDX_ERROR, {24'h0, `ERR_ABORT});
            rd_chk(`IDX_ID59, ok ? {16'h0, `ID59_ENABLED, cnts[i]} : 32'h0);
        end
    endtask

    // Soft reset must keep the mode; a hardware reset must drop it.
    task automatic t_resets();
        wr(`IDX_SECCNT, 32'h10);
        run_cmd(`CMD_SET_MULT, 8'h50);
        wr(`IDX_DEVCTL, 32'h4);
        wr(`IDX_DEVCTL, 32'h0);
        rd_chk(`IDX_ID59, 32'h0110);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(`IDX_ID59, 32'h0);
    endtask

    // The device-select bit is set on purpose; the command must run anyway.
    task automatic t_diag(input logic pres, input logic ok, input logic [7:0] code);
        present <= pres;
        dev1_ok <= ok;
        own_code <= code;
        wr(`IDX_DRVHEAD, 32'h10);
        run_cmd(`CMD_DIAG, 8'h50);
        rd_chk(`IDX_ERROR, {24'h0, (pres && !ok) ? (code | `DIAG_DEV1_FAIL) : code});
        rd_chk(`IDX_SECCNT, 32'h01);
        rd_chk(`IDX_DRVHEAD, 32'h00);
        if (pres && !ok) begin
            wr(`IDX_DRVHEAD, 32'h10);
            rd_chk(`IDX_DRVHEAD, 32'h10);
        end
    endtask

    task automatic t_format();
        wr(`IDX_CMDSTAT, {24'h0, `CMD_FMT_TRACK});
        rd_chk(`IDX_CMDSTAT, 32'h58);
        wr(`IDX_SECCNT, 32'h77);
        for (int i = 0; i < `PARAM_WORDS; i++) begin
            check({31'h0, intrq}, 32'h0);
            wr(`IDX_DATA, 32'hA500 + i);
        end
        wait_irq(5);
        rd_chk(`IDX_CMDSTAT, 32'h50);
        rd_chk(`IDX_SECCNT, 32'h01);
        rd_chk(`IDX_DATA, 32'hA500);
    endtask

    // Main sequence: reset for two cycles, then every scenario in turn.
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        sel = 4'h0;
        adr = 12'h000;
        wdat = 32'h0;
        present = 1'b0;
        dev1_ok = 1'b1;
        own_code = `DIAG_OK;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_ce();
        t_set_mult();
        t_resets();
        t_diag(1'b0, 1'b1, `DIAG_OK);
        t_diag(1'b0, 1'b1, `DIAG_BUF_ERR);
        t_diag(1'b0, 1'b1, `DIAG_ROM_ERR);
        t_diag(1'b1, 1'b1, `DIAG_OK);
        t_diag(1'b1, 1'b0, `DIAG_BUF_ERR);
        t_format();
        end_of_test();
    end
endmodule
`default_nettype wire
